/* File: inc/msd_cfg.svh */
// Constants for the memory-space decoder: offsets, field positions, reset values.
// Assumes inclusion by bare name from the design modules.
// Functional notes
// - Select low at reset fetches external code.
// - Internal fetches F800H-FFFFH return NOP, never external.
// - Lower 128 RAM bytes reachable directly and indirectly.
// - Upper 128 RAM bytes reachable only indirectly.
// - Lowest 32 bytes: four banks, eight registers each.
// - Bytes 20H-2FH bit-addressable as bits 00H-7FH.
// - Stack pointer resets to 07H, pre-increments on push.
// - Normal stack wraps FFH to 00H in RAM.
// - Config bit 7 widens stack to 11 bits.
// - Low pointer at 81H, upper three bits at B7H.
// - 1792 auxiliary RAM bytes usable as extended stack.
// - External data move generates all external strobes itself.
// - External data space spans 24-bit, 16 MBytes.
// - Config bit maps bottom 2 kBytes to auxiliary RAM.
// - Auxiliary RAM accesses leave ports 0, 2 undriven.
// - Special-function space is upper 128, direct only.
// - Nonvolatile data memory reached only through SFR registers.
`ifndef MSD_CFG_SVH
`define MSD_CFG_SVH
`define MSD_SFR_SP_LOW 8'h81
`define MSD_SFR_SP_UPPER 8'hb7
`define MSD_SP_RESET 11'h007
`define MSD_SP_UPPER_W 3
`define MSD_CODE_NOP_BASE 16'hf800
`define MSD_NOP_OPCODE 8'h00
`define MSD_SFR_BASE_BIT 7
`define MSD_BIT_RAM_BASE 8'h20
`define MSD_AUX_RAM_TOP 24'h000800
`endif

/* File: inc/msd_pkg.sv */
// Types shared by the memory-space decoder modules.
// Assumes msd_cfg.svh supplies the numeric constants.
package msd_pkg;
  typedef enum logic [1:0] {
    MSD_XB_IDLE = 2'b00,
    MSD_XB_ADDR = 2'b01,
    MSD_XB_STRB = 2'b11,
    MSD_XB_DONE = 2'b10
  } msd_xbus_state_t;
  typedef logic [10:0] msd_sp_t;
endpackage : msd_pkg

/* File: hw/msd_stack.sv */
// Stack pointer with optional 11-bit extension into auxiliary RAM.
// Assumes push, pop and SFR writes are one-cycle pulses, never together.
`timescale 1ns/1ps
`include "msd_cfg.svh"
module msd_stack (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Control
  input wire logic ext_stack_en,
  input wire logic push,
  input wire logic pop,
  input wire logic sp_low_we,
  input wire logic sp_upper_we,
  input wire logic [7:0] wdata,
  // State
  output msd_pkg::msd_sp_t sp_r
);
  msd_pkg::msd_sp_t sp_nxt;

  always_comb begin
    sp_nxt = sp_r;
    if (sp_low_we) begin
      sp_nxt = {sp_r[10:8], wdata};
    end else if (sp_upper_we) begin
      sp_nxt = {wdata[2:0], sp_r[7:0]};
    end else if (push) begin
      sp_nxt = sp_r + 11'h001;
    end else if (pop) begin
      sp_nxt = sp_r - 11'h001;
    end
    // Clearing the top bits makes the 8-bit wrap fall out of the same adder.
    if (!ext_stack_en) begin
      sp_nxt[10:8] = 3'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sp_r <= `MSD_SP_RESET;
    end else begin
      sp_r <= sp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_sp_reset_val: assert property ($past(!reset_n) |-> sp_r == 11'h007)
    else $error("stack pointer not 07H after reset");
  a_push_preinc: assert property (push && !sp_low_we && !sp_upper_we && sp_r == 11'h007
      |=> sp_r == 11'h008)
    else $error("first push does not land at 08H");
  a_wrap_normal: assert property (push && !ext_stack_en && sp_r[7:0] == 8'hff
      && !sp_low_we && !sp_upper_we |=> sp_r == 11'h000)
    else $error("normal stack does not wrap to 00H");
  a_wrap_extend: assert property (push && ext_stack_en && sp_r == 11'h0ff
      && !sp_low_we && !sp_upper_we |=> sp_r == 11'h100)
    else $error("extended stack does not continue to 0100H");
  a_upper_zero: assert property (!ext_stack_en ##1 !ext_stack_en |-> sp_r[10:8] == 3'h0)
    else $error("upper pointer bits nonzero with extension off");
endmodule : msd_stack

/* File: hw/msd_xdata.sv */
// External data space decoder and bus sequencer for 24-bit accesses.
// Assumes the auxiliary RAM answers combinationally and port inputs are synchronous.
`timescale 1ns/1ps
`include "msd_cfg.svh"
module msd_xdata (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Core request
  input wire logic xreq,
  input wire logic xwe,
  input wire logic [23:0] xaddr,
  input wire logic [7:0] xwdata,
  input wire logic aux_map_en,
  output logic xready,
  output logic xdone,
  output logic [7:0] xrdata_r,
  // Auxiliary RAM
  output logic aux_sel,
  output logic aux_we,
  output logic [10:0] aux_addr,
  input wire logic [7:0] aux_rdata,
  // External bus pins
  input wire logic [7:0] p0_in,
  output logic [7:0] p0_out,
  output logic p0_oe,
  output logic [7:0] p2_out,
  output logic p2_oe,
  output logic ale,
  output logic rd_strobe_n,
  output logic wr_strobe_n
);
  msd_pkg::msd_xbus_state_t state_r;
  logic [23:0] addr_r;
  logic [7:0] wdata_r;
  logic we_r;
  logic aux_done_r;
  logic aux_hit;
  logic accept;

  assign xready = (state_r == msd_pkg::MSD_XB_IDLE);
  assign accept = xreq && xready;
  assign aux_hit = aux_map_en && (xaddr < `MSD_AUX_RAM_TOP);
  assign aux_sel = accept && aux_hit;
  assign aux_we = aux_sel && xwe;
  assign aux_addr = xaddr[10:0];
  assign xdone = aux_done_r || (state_r == msd_pkg::MSD_XB_DONE);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_r <= msd_pkg::MSD_XB_IDLE;
    end else begin
      unique case (state_r)
        msd_pkg::MSD_XB_IDLE: if (accept && !aux_hit) state_r <= msd_pkg::MSD_XB_ADDR;
        msd_pkg::MSD_XB_ADDR: state_r <= msd_pkg::MSD_XB_STRB;
        msd_pkg::MSD_XB_STRB: state_r <= msd_pkg::MSD_XB_DONE;
        msd_pkg::MSD_XB_DONE: state_r <= msd_pkg::MSD_XB_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      addr_r <= 24'h000000;
      wdata_r <= 8'h00;
      we_r <= 1'b0;
    end else if (accept) begin
      addr_r <= xaddr;
      wdata_r <= xwdata;
      we_r <= xwe;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      aux_done_r <= 1'b0;
      xrdata_r <= 8'h00;
    end else begin
      aux_done_r <= aux_sel;
      if (aux_sel && !xwe) begin
        xrdata_r <= aux_rdata;
      end else if (state_r == msd_pkg::MSD_XB_STRB && !we_r) begin
        xrdata_r <= p0_in;
      end
    end
  end

  // The address phase latches the low byte on port 0 and the page byte on
  // port 2 together; port 2 then carries the middle byte during the strobe.
  always_comb begin
    p0_out = 8'h00;
    p2_out = 8'h00;
    p0_oe = 1'b0;
    p2_oe = 1'b0;
    if (state_r == msd_pkg::MSD_XB_ADDR) begin
      p0_out = addr_r[7:0];
      p2_out = addr_r[23:16];
      p0_oe = 1'b1;
      p2_oe = 1'b1;
    end else if (state_r == msd_pkg::MSD_XB_STRB) begin
      p0_out = wdata_r;
      p2_out = addr_r[15:8];
      p0_oe = we_r;
      p2_oe = 1'b1;
    end
  end

  assign ale = (state_r == msd_pkg::MSD_XB_ADDR);
  assign rd_strobe_n = !(state_r == msd_pkg::MSD_XB_STRB && !we_r);
  assign wr_strobe_n = !(state_r == msd_pkg::MSD_XB_STRB && we_r);

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_addr_phase;
    ale && p0_oe && p2_oe;
  endsequence
  sequence s_strobe_phase;
    !ale && (!rd_strobe_n || !wr_strobe_n);
  endsequence

  a_ext_strobe_seq: assert property (accept && !aux_hit
      |=> s_addr_phase ##1 s_strobe_phase ##1 xdone)
    else $error("external strobe sequence broken");
  a_aux_bus_idle: assert property (aux_sel |-> !p0_oe && !p2_oe
      ##1 !ale && !p0_oe && xdone)
    else $error("ports driven during auxiliary RAM access");
  a_aux_window: assert property (aux_sel |-> aux_map_en && xaddr[23:11] == 13'h0000)
    else $error("auxiliary RAM selected outside bottom 2 kBytes");
  a_page_byte_out: assert property (accept && !aux_hit |=> p2_out == $past(xaddr[23:16]))
    else $error("page byte missing in address phase");
endmodule : msd_xdata

/* File: hw/msd_top.sv */
// Memory-space decoder: code fetch select, internal data decode, stack, external data.
// Assumes a core that issues one-cycle requests and sees answers one cycle later.
`timescale 1ns/1ps
`include "msd_cfg.svh"
module msd_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Strap and configuration
  input wire logic external_code_select,
  input wire logic cfg_ext_stack_en,
  input wire logic cfg_aux_map_en,
  // Code fetch
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  output logic flash_rd,
  output logic [15:0] flash_addr,
  input wire logic [7:0] flash_rdata,
  output logic ext_code_rd,
  output logic [15:0] ext_code_addr,
  input wire logic [7:0] ext_code_rdata,
  output logic fetch_valid,
  output logic [7:0] fetch_data_r,
  output logic ext_code_mode_r,
  // Internal data access
  input wire logic dmem_req,
  input wire logic dmem_indirect,
  input wire logic dmem_we,
  input wire logic [7:0] dmem_addr,
  input wire logic [7:0] dmem_wdata,
  output logic iram_sel,
  output logic [7:0] iram_addr,
  output logic sfr_sel,
  output logic sfr_local_hit,
  output logic [7:0] sfr_rdata_r,
  // Register bank and bit decode
  input wire logic [1:0] bank_sel,
  input wire logic [2:0] bank_reg_num,
  output logic [7:0] bank_reg_addr,
  input wire logic [7:0] bit_addr,
  output logic bit_in_sfr,
  output logic [7:0] bit_byte_addr,
  output logic [2:0] bit_pos,
  // Stack
  input wire logic stack_push,
  input wire logic stack_pop,
  output logic [10:0] stack_addr,
  output logic stack_in_aux,
  // External data
  input wire logic xreq,
  input wire logic xwe,
  input wire logic [23:0] xaddr,
  input wire logic [7:0] xwdata,
  output logic xready,
  output logic xdone,
  output logic [7:0] xrdata_r,
  output logic aux_sel,
  output logic aux_we,
  output logic [10:0] aux_addr,
  input wire logic [7:0] aux_rdata,
  // External bus pins
  input wire logic [7:0] p0_in,
  output logic [7:0] p0_out,
  output logic p0_oe,
  output logic [7:0] p2_out,
  output logic p2_oe,
  output logic ale,
  output logic rd_strobe_n,
  output logic wr_strobe_n
);
  msd_pkg::msd_sp_t sp_r;
  logic sp_low_we;
  logic sp_upper_we;
  logic nop_zone;
  logic fetch_nop_r;
  logic fetch_ext_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Code fetch. The strap is sampled on every reset cycle, so the level held
  // as reset is released decides the mode until the next reset.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ext_code_mode_r <= !external_code_select;
    end
  end

  assign nop_zone = (fetch_addr >= `MSD_CODE_NOP_BASE);
  assign flash_rd = fetch_req && !ext_code_mode_r && !nop_zone;
  assign flash_addr = fetch_addr;
  // No rollover: the top 2 kBytes never reach the external bus in internal mode.
  assign ext_code_rd = fetch_req && ext_code_mode_r;
  assign ext_code_addr = fetch_addr;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      fetch_valid <= 1'b0;
      fetch_nop_r <= 1'b0;
      fetch_ext_r <= 1'b0;
      fetch_data_r <= `MSD_NOP_OPCODE;
    end else begin
      fetch_valid <= fetch_req;
      fetch_nop_r <= fetch_req && !ext_code_mode_r && nop_zone;
      fetch_ext_r <= fetch_req && ext_code_mode_r;
      if (fetch_req) begin
        if (ext_code_mode_r) begin
          fetch_data_r <= ext_code_rdata;
        end else if (nop_zone) begin
          fetch_data_r <= `MSD_NOP_OPCODE;
        end else begin
          fetch_data_r <= flash_rdata;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Internal data space. Direct addresses with the top bit set select the
  // special-function space; indirect ones always reach RAM. The nonvolatile
  // data memory has no window here: its control registers live in the SFR
  // space outside this block, which is its only path.
  always_comb begin
    iram_sel = 1'b0;
    sfr_sel = 1'b0;
    if (dmem_req) begin
      if (!dmem_indirect && dmem_addr[`MSD_SFR_BASE_BIT]) begin
        sfr_sel = 1'b1;
      end else begin
        iram_sel = 1'b1;
      end
    end
  end
  assign iram_addr = dmem_addr;

  assign sfr_local_hit = sfr_sel && (dmem_addr == `MSD_SFR_SP_LOW
      || dmem_addr == `MSD_SFR_SP_UPPER);
  assign sp_low_we = sfr_sel && dmem_we && dmem_addr == `MSD_SFR_SP_LOW;
  assign sp_upper_we = sfr_sel && dmem_we && dmem_addr == `MSD_SFR_SP_UPPER;

  // Read data is registered and follows the request by one cycle; unused
  // upper bits of the upper pointer register read as zero.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sfr_rdata_r <= 8'h00;
    end else if (sfr_sel && !dmem_we) begin
      if (dmem_addr == `MSD_SFR_SP_LOW) begin
        sfr_rdata_r <= sp_r[7:0];
      end else if (dmem_addr == `MSD_SFR_SP_UPPER) begin
        sfr_rdata_r <= {5'h00, sp_r[10:8]};
      end else begin
        sfr_rdata_r <= 8'h00;
      end
    end
  end

  assign bank_reg_addr = {3'h0, bank_sel, bank_reg_num};

  always_comb begin
    bit_pos = bit_addr[2:0];
    bit_in_sfr = bit_addr[7];
    if (bit_addr[7]) begin
      bit_byte_addr = {bit_addr[7:3], 3'h0};
    end else begin
      bit_byte_addr = `MSD_BIT_RAM_BASE + {4'h0, bit_addr[6:3]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  msd_stack u_stack (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .ext_stack_en(cfg_ext_stack_en),
    .push(stack_push),
    .pop(stack_pop),
    .sp_low_we(sp_low_we),
    .sp_upper_we(sp_upper_we),
    .wdata(dmem_wdata),
    .sp_r(sp_r)
  );
  assign stack_addr = sp_r;
  assign stack_in_aux = (sp_r[10:8] != 3'h0);

  msd_xdata u_xdata (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .xreq(xreq),
    .xwe(xwe),
    .xaddr(xaddr),
    .xwdata(xwdata),
    .aux_map_en(cfg_aux_map_en),
    .xready(xready),
    .xdone(xdone),
    .xrdata_r(xrdata_r),
    .aux_sel(aux_sel),
    .aux_we(aux_we),
    .aux_addr(aux_addr),
    .aux_rdata(aux_rdata),
    .p0_in(p0_in),
    .p0_out(p0_out),
    .p0_oe(p0_oe),
    .p2_out(p2_out),
    .p2_oe(p2_oe),
    .ale(ale),
    .rd_strobe_n(rd_strobe_n),
    .wr_strobe_n(wr_strobe_n)
  );

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_nop_fill: assert property (fetch_req && !ext_code_mode_r && fetch_addr[15:11] == 5'h1f
      |-> !ext_code_rd && !flash_rd ##1 fetch_valid && fetch_nop_r && fetch_data_r == 8'h00)
    else $error("fetch above F7FFH not answered with NOP");
  a_ext_code_path: assert property (fetch_req && ext_code_mode_r
      |-> ext_code_rd && !flash_rd ##1 fetch_ext_r && fetch_data_r == $past(ext_code_rdata))
    else $error("external code mode not fetching externally");
  a_direct_sfr: assert property (dmem_req && !dmem_indirect && dmem_addr >= 8'h80
      |-> sfr_sel && !iram_sel)
    else $error("direct upper address reached RAM");
  a_indirect_ram: assert property (dmem_req && (dmem_indirect || dmem_addr < 8'h80)
      |-> iram_sel && !sfr_sel)
    else $error("RAM address not routed to RAM");
  a_sp_readback: assert property (sfr_sel && !dmem_we && dmem_addr == 8'hb7
      |=> sfr_rdata_r[7:3] == 5'h00 && sfr_rdata_r[2:0] == $past(sp_r[10:8]))
    else $error("upper pointer readback wrong");
  a_bit_region: assert property (!bit_addr[7] |-> bit_byte_addr >= 8'h20
      && bit_byte_addr <= 8'h2f)
    else $error("bit address outside 20H-2FH");
endmodule : msd_top

/* File: tb/msd_ext_mem.sv */
// External program and data memory model on the far side of the bus pins.
// Assumes one-cycle address and strobe phases, all on the core clock.
`timescale 1ns/1ps
module msd_ext_mem (
  // Clock
  input wire logic ref_clk,
  // Code memory
  input wire logic ext_code_rd,
  input wire logic [15:0] ext_code_addr,
  output logic [7:0] ext_code_rdata,
  // Data bus
  input wire logic [7:0] p0_out,
  input wire logic p0_oe,
  input wire logic [7:0] p2_out,
  input wire logic ale,
  input wire logic rd_strobe_n,
  input wire logic wr_strobe_n,
  output logic [7:0] p0_in,
  output logic [23:0] wr_addr_r,
  output logic [7:0] wr_data_r
);
  logic [7:0] lo_r = 8'h00;
  logic [7:0] page_r = 8'h00;
  logic [7:0] last_r = 8'h00;
  // A released bus toggles every cycle, so a stale byte is never read as an answer.
  assign ext_code_rdata = ext_code_rd ? (ext_code_addr[7:0] ^ ext_code_addr[15:8] ^ 8'h5a)
                                      : ~last_r;
  assign p0_in = !rd_strobe_n ? (lo_r ^ p2_out ^ page_r ^ 8'h3c) : (p0_oe ? p0_out : ~last_r);
  always_ff @(posedge ref_clk) begin
    last_r <= p0_in;
    if (ale) begin
      lo_r <= p0_out;
      page_r <= p2_out;
    end
    if (!wr_strobe_n) begin
      wr_addr_r <= {page_r, p2_out, lo_r};
      wr_data_r <= p0_out;
    end
  end
endmodule : msd_ext_mem

/* File: tb/tb.sv */
// Self-checking bench for the memory-space decoder top level.
// Assumes the external memory model and combinational on-chip memories below.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks = checks + 1; if ((got) !== (ex)) begin \
  errors = errors + 1; $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb;
  logic ref_clk = 1'b0, reset_n = 1'b0, external_code_select = 1'b1;
  logic cfg_ext_stack_en = 1'b0, cfg_aux_map_en = 1'b0, fetch_req = 1'b0;
  logic dmem_req = 1'b0, dmem_indirect = 1'b0, dmem_we = 1'b0, stack_push = 1'b0;
  logic stack_pop = 1'b0, xreq = 1'b0, xwe = 1'b0;
  logic [15:0] fetch_addr = 16'h0000;
  logic [7:0] dmem_addr = 8'h00, dmem_wdata = 8'h00, bit_addr = 8'h00, xwdata = 8'h00;
  logic [1:0] bank_sel = 2'h0;
  logic [2:0] bank_reg_num = 3'h0;
  logic [23:0] xaddr = 24'h000000;
  logic flash_rd, ext_code_rd, fetch_valid, ext_code_mode_r, iram_sel, sfr_sel, sfr_local_hit;
  logic bit_in_sfr, stack_in_aux, xready, xdone, aux_sel, aux_we, p0_oe, p2_oe, ale;
  logic rd_strobe_n, wr_strobe_n;
  logic [15:0] flash_addr, ext_code_addr;
  logic [7:0] flash_rdata, ext_code_rdata, fetch_data_r, iram_addr, sfr_rdata_r, bank_reg_addr;
  logic [7:0] bit_byte_addr, xrdata_r, aux_rdata, p0_in, p0_out, p2_out, wr_data_r;
  logic [2:0] bit_pos;
  logic [10:0] stack_addr, aux_addr;
  logic [23:0] wr_addr_r;
  int errors = 0;
  int checks = 0;
  assign flash_rdata = flash_rd ? (flash_addr[7:0] ^ 8'ha5) : 8'hff;
  assign aux_rdata = aux_sel ? (aux_addr[7:0] + 8'h11) : 8'hee;

  msd_top uut (.ref_clk, .reset_n, .external_code_select, .cfg_ext_stack_en, .cfg_aux_map_en,
    .fetch_req, .fetch_addr, .flash_rd, .flash_addr, .flash_rdata, .ext_code_rd,
    .ext_code_addr, .ext_code_rdata, .fetch_valid, .fetch_data_r, .ext_code_mode_r,
    .dmem_req, .dmem_indirect, .dmem_we, .dmem_addr, .dmem_wdata, .iram_sel, .iram_addr,
    .sfr_sel, .sfr_local_hit, .sfr_rdata_r, .bank_sel, .bank_reg_num, .bank_reg_addr,
    .bit_addr, .bit_in_sfr, .bit_byte_addr, .bit_pos, .stack_push, .stack_pop, .stack_addr,
    .stack_in_aux, .xreq, .xwe, .xaddr, .xwdata, .xready, .xdone, .xrdata_r, .aux_sel,
    .aux_we, .aux_addr, .aux_rdata, .p0_in, .p0_out, .p0_oe, .p2_out, .p2_oe, .ale,
    .rd_strobe_n, .wr_strobe_n);
  msd_ext_mem mem (.ref_clk, .ext_code_rd, .ext_code_addr, .ext_code_rdata, .p0_out, .p0_oe,
    .p2_out, .ale, .rd_strobe_n, .wr_strobe_n, .p0_in, .wr_addr_r, .wr_data_r);

  ////////////////////////////////////////////////////////////////////////////////
  task finish_test;
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test

  task idle;
    @(posedge ref_clk);
    fetch_req <= 1'b0;
    dmem_req <= 1'b0;
    stack_push <= 1'b0;
    stack_pop <= 1'b0;
    xreq <= 1'b0;
    #1;
  endtask : idle

  task do_reset(input logic ecs);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    external_code_select <= ecs;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1;
  endtask : do_reset

  task fetch(input logic [15:0] a, input logic [1:0] rd, input logic [7:0] ex);
    @(posedge ref_clk);
    fetch_req <= 1'b1;
    fetch_addr <= a;
    #1;
    `CHK("code_rd", rd, {flash_rd, ext_code_rd})
    idle;
    `CHK("fetch_valid", 1'b1, fetch_valid)
    `CHK("fetch_data_r", ex, fetch_data_r)
  endtask : fetch

  task dreq(input logic ind, input logic we, input logic [7:0] a, input logic [7:0] wd);
    @(posedge ref_clk);
    dmem_req <= 1'b1;
    dmem_indirect <= ind;
    dmem_we <= we;
    dmem_addr <= a;
    dmem_wdata <= wd;
    #1;
  endtask : dreq

  task stk(input logic up);
    @(posedge ref_clk);
    // A pending pointer write would outrank the push, so the request ends here.
    dmem_req <= 1'b0;
    if (up) stack_push <= 1'b1;
    else stack_pop <= 1'b1;
    idle;
  endtask : stk

  task xfer(input logic we, input logic [23:0] a, input logic [7:0] wd, input logic aux);
    @(posedge ref_clk);
    xreq <= 1'b1;
    xwe <= we;
    xaddr <= a;
    xwdata <= wd;
    #1;
    `CHK("aux_sel", {aux, aux & we, a[10:0], 1'b1}, {aux_sel, aux_we, aux_addr, xready})
    idle;
    if (aux) begin
      `CHK("xdone", 1'b1, xdone)
      `CHK("port_oe", 2'b00, {p0_oe, p2_oe})
      if (!we) `CHK("xrdata_r", a[7:0] + 8'h11, xrdata_r)
    end else begin
      `CHK("addr_phase", {1'b1, a[7:0], a[23:16], 2'b11},
           {ale, p0_out, p2_out, p0_oe, p2_oe})
      @(posedge ref_clk);
      #1;
      `CHK("p2_out", a[15:8], p2_out)
      `CHK("strobes", {we, !we, we, 1'b0}, {rd_strobe_n, wr_strobe_n, p0_oe, xready})
      @(posedge ref_clk);
      #1;
      `CHK("xdone", 1'b1, xdone)
      if (!we) `CHK("xrdata_r", a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3c, xrdata_r)
      else `CHK("written", {a, wd}, {wr_addr_r, wr_data_r})
      @(posedge ref_clk);
      #1;
    end
  endtask : xfer

  ////////////////////////////////////////////////////////////////////////////////
  initial forever #4 ref_clk = ~ref_clk;

  initial begin
    #(8 * 20000);
    errors = errors + 1;
    finish_test;
  end

  initial begin
    logic [7:0] b;
    do_reset(1'b1);
    `CHK("ext_code_mode_r", 1'b0, ext_code_mode_r)
    fetch(16'h0100, 2'b10, 8'h00 ^ 8'ha5);
    fetch(16'hf7ff, 2'b10, 8'hff ^ 8'ha5);
    fetch(16'hf800, 2'b00, 8'h00);
    fetch(16'hffff, 2'b00, 8'h00);
    dreq(1'b0, 1'b0, 8'h81, 8'h00);
    `CHK("sel_81", 3'b011, {iram_sel, sfr_sel, sfr_local_hit})
    idle;
    `CHK("sp_low_reset", 8'h07, sfr_rdata_r)
    dreq(1'b0, 1'b0, 8'h30, 8'h00);
    `CHK("direct_low", 2'b10, {iram_sel, sfr_sel})
    dreq(1'b1, 1'b0, 8'h30, 8'h00);
    `CHK("indirect_low", 2'b10, {iram_sel, sfr_sel})
    dreq(1'b1, 1'b0, 8'h90, 8'h00);
    `CHK("indirect_high", {2'b10, 8'h90}, {iram_sel, sfr_sel, iram_addr})
    dreq(1'b0, 1'b0, 8'h90, 8'h00);
    `CHK("direct_high", 3'b010, {iram_sel, sfr_sel, sfr_local_hit})
    idle;
    `CHK("sfr_other", 8'h00, sfr_rdata_r)
    for (int k = 0; k < 256; k++) begin
      b = k[7:0];
      @(posedge ref_clk);
      bank_sel <= b[4:3];
      bank_reg_num <= b[2:0];
      bit_addr <= b;
      #1;
      if (k < 32) `CHK("bank_reg_addr", b, bank_reg_addr)
      `CHK("bit_decode", {b[7], b[7] ? {b[7:3], 3'h0} : 8'h20 + b[6:3], b[2:0]},
           {bit_in_sfr, bit_byte_addr, bit_pos})
    end
    stk(1'b1);
    `CHK("stack_addr", 12'h008, {stack_in_aux, stack_addr})
    dreq(1'b0, 1'b1, 8'h81, 8'hff);
    stk(1'b1);
    `CHK("stack_addr", 11'h000, stack_addr)
    dreq(1'b0, 1'b1, 8'hb7, 8'h05);
    idle;
    `CHK("stack_addr", 11'h000, stack_addr)
    cfg_ext_stack_en <= 1'b1;
    dreq(1'b0, 1'b1, 8'h81, 8'hff);
    stk(1'b1);
    `CHK("stack_ext", 12'h900, {stack_in_aux, stack_addr})
    dreq(1'b0, 1'b1, 8'hb7, 8'h07);
    dreq(1'b0, 1'b1, 8'h81, 8'hfe);
    stk(1'b1);
    `CHK("stack_addr", 11'h7ff, stack_addr)
    stk(1'b0);
    `CHK("stack_addr", 11'h7fe, stack_addr)
    dreq(1'b0, 1'b0, 8'hb7, 8'h00);
    idle;
    `CHK("sp_upper", 8'h07, sfr_rdata_r)
    cfg_aux_map_en <= 1'b1;
    xfer(1'b1, 24'h000010, 8'ha5, 1'b1);
    xfer(1'b0, 24'h0007ff, 8'h00, 1'b1);
    xfer(1'b0, 24'h000800, 8'h00, 1'b0);
    xfer(1'b0, 24'h123456, 8'h00, 1'b0);
    xfer(1'b1, 24'habcdef, 8'h3c, 1'b0);
    cfg_aux_map_en <= 1'b0;
    xfer(1'b1, 24'h000010, 8'h77, 1'b0);
    do_reset(1'b0);
    `CHK("ext_code_mode_r", 1'b1, ext_code_mode_r)
    `CHK("stack_addr", 11'h007, stack_addr)
    fetch(16'hf800, 2'b01, 8'hf8 ^ 8'h5a);
    finish_test;
  end
endmodule : tb
